// File: design/scdt_pkg.sv
`default_nettype none
package scdt_pkg;
  localparam logic [7:0] ESC_BYTE = 8'h0F;
  localparam logic [7:0] OP_SGE = 8'h9D;
  localparam logic [7:0] OP_SGT = 8'h9F;
  localparam logic [7:0] OP_NO = 8'h91;
  localparam logic [7:0] OP_PO = 8'h9B;
  localparam logic [7:0] OP_NS = 8'h99;
  localparam logic [7:0] OP_OV = 8'h90;
  localparam logic [7:0] OP_PE = 8'h9A;
  localparam logic [7:0] OP_SG = 8'h98;
  localparam logic [7:0] OP_DT = 8'h01;
  localparam logic [2:0] REG_SEL = 3'h0;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [3:0] CLK_SETCC = 4'h2;
  localparam logic [3:0] CLK_STORE_DT = 4'h6;
  // busy count at which the instruction completes
  localparam logic [3:0] CNT_FINAL = 4'h2;
  localparam int MODRM_MOD_HI = 7;
  localparam int MODRM_MOD_LO = 6;
  localparam int MODRM_REG_HI = 5;
  localparam int MODRM_REG_LO = 3;
  localparam int MODRM_RM_HI = 2;
  localparam int MODRM_RM_LO = 0;

  typedef enum logic [3:0] {
    SCDT_OP_NONE = 4'h0,
    SCDT_OP_SET_IF_SIGNED_GE = 4'h1,
    SCDT_OP_SET_IF_SIGNED_GREATER = 4'h2,
    SCDT_OP_SET_IF_NO_OVERFLOW = 4'h3,
    SCDT_OP_SET_IF_ODD_PARITY = 4'h4,
    SCDT_OP_SET_IF_SIGN_CLEAR = 4'h5,
    SCDT_OP_SET_IF_OVERFLOW = 4'h6,
    SCDT_OP_SET_IF_EVEN_PARITY = 4'h7,
    SCDT_OP_SET_IF_SIGN_FLAG = 4'h8,
    SCDT_OP_STORE_GLOBAL_DT = 4'h9
  } scdt_op_t;

  typedef enum logic [1:0] {
    SCDT_IDLE = 2'h0,
    SCDT_BUSY = 2'h1
  } scdt_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
  } scdt_insn_t;

  typedef struct packed {
    logic of;
    logic sf;
    logic zf;
    logic pf;
  } scdt_flags_t;

  typedef struct packed {
    logic valid;
    logic is_mem;
    logic [2:0] rm;
    logic [7:0] value;
  } scdt_wr_t;
endpackage
`default_nettype wire

// File: design/scdt_decode.sv
// Summary of operation
// - 0F 9D reg 000 set_if_sign_flag byte if signed greater or equal, 2 clocks.
// - 0F 9F reg 000 set_if_sign_flag byte if signed greater, 2 clocks.
// - 0F 91 reg 000 set_if_sign_flag byte if overflow clear, 2 clocks.
// - 0F 9B set_if_sign_flag byte if parity flag clear, 2 clocks.
// - 0F 99 set_if_sign_flag byte if sign flag clear, 2 clocks.
// - 0F 90 set_if_sign_flag byte if overflow flag set, 2 clocks.
// - 0F 9A set_if_sign_flag byte if parity flag set, 2 clocks.
// - 0F 98 set_if_sign_flag byte if sign flag set, 2 clocks.
// - 0F 01 reg 000 stores descriptor table register, 6 clocks, any case.
`default_nettype none
module scdt_decode
  import scdt_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic insn_valid,
  input wire scdt_pkg::scdt_insn_t insn,
  input wire scdt_pkg::scdt_flags_t flags,
  output logic insn_ready,
  output scdt_pkg::scdt_op_t op_q,
  output logic illegal_q,
  output scdt_pkg::scdt_wr_t wr_q,
  output logic global_descriptor_table_store_q,
  output logic done_q
);
  import scdt_pkg::*;

  scdt_state_t state_q;
  scdt_state_t state_d;
  scdt_op_t op_d;
  scdt_op_t dec_op;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic illegal_d;
  logic cond;
  logic global_descriptor_table_store_d;
  logic done_d;
  logic ready_q;
  logic ready_d;
  logic take;
  logic refuse;
  logic finish;
  scdt_wr_t wr_d;
  logic [1:0] md;
  logic [2:0] rg;

  assign md = insn.modrm[MODRM_MOD_HI:MODRM_MOD_LO];
  assign rg = insn.modrm[MODRM_REG_HI:MODRM_REG_LO];
  assign insn_ready = ready_q;

  // escape byte is consumed upstream; opcode is the second byte
  always_comb begin
    dec_op = SCDT_OP_NONE;
    if (rg == REG_SEL) begin
      case (insn.opcode)
        OP_SGE: dec_op = SCDT_OP_SET_IF_SIGNED_GE;
        OP_SGT: dec_op = SCDT_OP_SET_IF_SIGNED_GREATER;
        OP_NO: dec_op = SCDT_OP_SET_IF_NO_OVERFLOW;
        OP_PO: dec_op = SCDT_OP_SET_IF_ODD_PARITY;
        OP_NS: dec_op = SCDT_OP_SET_IF_SIGN_CLEAR;
        OP_OV: dec_op = SCDT_OP_SET_IF_OVERFLOW;
        OP_PE: dec_op = SCDT_OP_SET_IF_EVEN_PARITY;
        OP_SG: dec_op = SCDT_OP_SET_IF_SIGN_FLAG;
        OP_DT: dec_op = SCDT_OP_STORE_GLOBAL_DT;
        default: dec_op = SCDT_OP_NONE;
      endcase
    end
  end

  always_comb begin
    case (op_q)
      SCDT_OP_SET_IF_SIGNED_GE: cond = (flags.sf == flags.of);
      SCDT_OP_SET_IF_SIGNED_GREATER: cond = !flags.zf && (flags.sf == flags.of);
      SCDT_OP_SET_IF_NO_OVERFLOW: cond = !flags.of;
      SCDT_OP_SET_IF_ODD_PARITY: cond = !flags.pf;
      SCDT_OP_SET_IF_SIGN_CLEAR: cond = !flags.sf;
      SCDT_OP_SET_IF_OVERFLOW: cond = flags.of;
      SCDT_OP_SET_IF_EVEN_PARITY: cond = flags.pf;
      SCDT_OP_SET_IF_SIGN_FLAG: cond = flags.sf;
      default: cond = 1'b0;
    endcase
  end

  // take and finish are shared by the control and the result group
  assign take = (state_q == SCDT_IDLE) && insn_valid && ready_q && (dec_op != SCDT_OP_NONE);
  // refused words never leave idle, so they may come back to back
  assign refuse = (state_q == SCDT_IDLE) && insn_valid && ready_q && (dec_op == SCDT_OP_NONE);
  assign finish = (state_q == SCDT_BUSY) && (cnt_q == CNT_FINAL);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ready_d = ready_q;
    op_d = op_q;
    case (state_q)
      SCDT_IDLE: begin
        if (take) begin
          state_d = SCDT_BUSY;
          ready_d = 1'b0;
          op_d = dec_op;
          // same count for hit, miss and both modes, so no cache input needed
          cnt_d = (dec_op == SCDT_OP_STORE_GLOBAL_DT) ? CLK_STORE_DT : CLK_SETCC;
        end
      end
      SCDT_BUSY: begin
        cnt_d = cnt_q - 4'h1;
        if (finish) begin
          state_d = SCDT_IDLE;
          ready_d = 1'b1;
          op_d = SCDT_OP_NONE;
        end
      end
      default: begin
        state_d = SCDT_IDLE;
        ready_d = 1'b1;
        op_d = SCDT_OP_NONE;
      end
    endcase
  end

  always_comb begin
    illegal_d = refuse;
    done_d = finish;
    global_descriptor_table_store_d = finish && (op_q == SCDT_OP_STORE_GLOBAL_DT);
    wr_d = wr_q;
    wr_d.valid = 1'b0;
    if (take) begin
      wr_d.is_mem = (md != MOD_REG);
      wr_d.rm = insn.modrm[MODRM_RM_HI:MODRM_RM_LO];
    end
    if (finish && (op_q != SCDT_OP_STORE_GLOBAL_DT)) begin
      // flags read in the last busy clock; the block never writes them
      wr_d.valid = 1'b1;
      wr_d.value = {7'h00, cond};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= SCDT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      op_q <= SCDT_OP_NONE;
    end else begin
      op_q <= op_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= illegal_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      global_descriptor_table_store_q <= 1'b0;
    end else begin
      global_descriptor_table_store_q <= global_descriptor_table_store_d;
    end
  end

  // destination fields hold after the pulse so a slow consumer can still read them
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_q <= '0;
    end else begin
      wr_q <= wr_d;
    end
  end
endmodule
`default_nettype wire

// File: verif/scdt_decode_asserts.sv
`default_nettype none
module scdt_decode_asserts
  import scdt_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic insn_valid,
  input wire scdt_pkg::scdt_insn_t insn,
  input wire scdt_pkg::scdt_flags_t flags,
  input wire logic insn_ready,
  input wire scdt_pkg::scdt_op_t op_q,
  input wire logic illegal_q,
  input wire scdt_pkg::scdt_wr_t wr_q,
  input wire logic global_descriptor_table_store_q,
  input wire logic done_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_set;
    $fell(insn_ready) ##0 op_q != SCDT_OP_STORE_GLOBAL_DT;
  endsequence
  sequence s_hold;
    !done_q [*4];
  endsequence
  a_setcc_two_clk: assert property (s_set |=> done_q && wr_q.valid) else $error("late");
  a_store_six_clk: assert property ($fell(insn_ready) && op_q == SCDT_OP_STORE_GLOBAL_DT
    |=> s_hold ##1 done_q && global_descriptor_table_store_q) else $error("store timing");
  a_reg_field_refused: assert property (insn_valid && insn_ready && insn.modrm[5:3] != REG_SEL
    |=> illegal_q && insn_ready) else $error("not refused");
  a_dest_kind: assert property (wr_q.valid
    |-> wr_q.is_mem == ($past(insn.modrm[7:6], 2) != MOD_REG)) else $error("dest kind");
  a_byte_value: assert property (wr_q.valid |-> wr_q.value[7:1] == 7'h00) else $error("value");
  a_ov_value: assert property ($fell(insn_ready) && op_q == SCDT_OP_SET_IF_OVERFLOW
    |=> wr_q.value[0] == $past(flags.of)) else $error("overflow value");
  a_ge_value: assert property ($fell(insn_ready) && op_q == SCDT_OP_SET_IF_SIGNED_GE
    |=> wr_q.value[0] == ($past(flags.sf) == $past(flags.of))) else $error("ge value");
  a_ready_back: assert property (done_q |-> insn_ready) else $error("ready");
endmodule
bind scdt_decode scdt_decode_asserts i_scdt_decode_asserts(.mclk, .sys_rst, .insn_valid, .insn, .flags,
  .insn_ready, .op_q, .illegal_q, .wr_q, .global_descriptor_table_store_q, .done_q);
`default_nettype wire

// File: verif/scdt_fetch_model.sv
`default_nettype none
module scdt_fetch_model
  import scdt_pkg::*;
(
  input wire logic mclk,
  input wire logic insn_ready,
  input wire logic go,
  input wire scdt_pkg::scdt_insn_t word,
  output logic insn_valid,
  output scdt_pkg::scdt_insn_t insn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tk = 1'b0;
  initial begin
    insn_valid = 1'b0;
    insn = '0;
  end
  always @(posedge mclk) tk <= insn_valid && insn_ready;
  // released lines invert so a stale opcode never looks fresh
  always @(negedge mclk) begin
    if (tk) begin
      insn_valid <= 1'b0;
      insn <= ~insn;
    end else if (go && !insn_valid) begin
      insn_valid <= 1'b1;
      insn <= word;
    end
  end
endmodule
`default_nettype wire

// File: verif/test_setcc_store_global_descriptor_table_decode_timing.sv
`default_nettype none
`define CHK(s, e, a) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", s, e, a); end end
module test_setcc_store_global_descriptor_table_decode_timing;
  timeunit 1ns;
  timeprecision 1ns;
  import scdt_pkg::*;
  logic mclk, sys_rst, go, insn_valid, insn_ready, illegal_q, global_descriptor_table_store_q, done_q;
  scdt_insn_t word, insn;
  scdt_flags_t flags;
  scdt_op_t op_q;
  scdt_wr_t wr_q;
  int mismatches, cmp_count;
  logic [3:0] n;
  scdt_decode i_scdt_decode(.mclk, .sys_rst, .insn_valid, .insn, .flags, .insn_ready, .op_q, .illegal_q,
    .wr_q, .global_descriptor_table_store_q, .done_q);
  scdt_fetch_model i_scdt_fetch_model(.mclk, .insn_ready, .go, .word, .insn_valid, .insn);
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  task run(input logic [15:0] w, input logic [3:0] f);
    @(negedge mclk);
    n = 0; word <= w; go <= 1; flags <= f;
    @(negedge mclk) go <= 0;
    do begin
      @(posedge mclk) #1 n++;
    end while (n < 15 && done_q !== 1 && illegal_q !== 1);
  endtask
  function logic cond(logic [7:0] o, scdt_flags_t f);
    case (o)
      OP_SGE: return f.sf == f.of;
      OP_SGT: return !f.zf && f.sf == f.of;
      OP_NO: return !f.of;
      OP_PO: return !f.pf;
      OP_NS: return !f.sf;
      OP_OV: return f.of;
      OP_PE: return f.pf;
      default: return f.sf;
    endcase
  endfunction
  task t_setcc;
    logic [7:0] ops [8];
    ops = '{OP_SGE, OP_SGT, OP_NO, OP_PO, OP_NS, OP_OV, OP_PE, OP_SG};
    for (int i = 0; i < 8; i++) for (int k = 0; k < 16; k++) begin
      run({ops[i], k[0] ? 8'hC5 : 8'h05}, k[3:0]);
      `CHK("set clocks", CLK_SETCC, n)
      `CHK("set value", {7'h00, cond(ops[i], flags)}, wr_q.value)
      `CHK("dest kind", ~k[0], wr_q.is_mem)
      `CHK("dest reg", 3'h5, wr_q.rm)
    end
  endtask
  task t_store;
    run({OP_DT, 8'h06}, 4'hF);
    `CHK("store clocks", CLK_STORE_DT, n)
    `CHK("store pulse", 1'b1, global_descriptor_table_store_q)
    `CHK("op idle", SCDT_OP_NONE, op_q)
  endtask
  task t_refuse;
    run({OP_SGE, 8'h48}, 4'h0);
    `CHK("reg refused", 2'h3, {illegal_q, insn_ready})
    run({8'h92, 8'hC0}, 4'h0);
    `CHK("op refused", 2'h2, {illegal_q, done_q})
  endtask
  task end_of_test;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    mismatches = 0; cmp_count = 0; go = 0; word = '0; flags = '0; sys_rst = 1;
    repeat (10) @(negedge mclk);
    sys_rst = 0;
    t_setcc;
    t_store;
    t_refuse;
    end_of_test;
  end
  // about 400 cycles of traffic, so 20000 is ample
  initial begin
    #2000000;
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
